/* design/ext_bus_if.sv */
// Purpose: external memory bus engine with Avalon-MM register slave
// Assumes: pins synchronous to clk; one access at a time
// Notes: software loads address/data, then sets go in control
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/10ps
module ext_bus_if (
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic bootModeSelect,
    input wire logic byteWidthSel,
    input wire logic holdReq_n,
    input wire logic waitReq_n,
    output logic [19:0] addrOut,
    output logic [15:0] dataOut,
    output logic [15:0] dataOe_n,
    input wire logic [15:0] dataIn,
    output logic addrLatch,
    output logic [3:0] space_select_n,
    output logic even_byte_store_strobe_n,
    output logic odd_byte_store_strobe_n,
    output logic readStrobe_n,
    output logic bus_grant_ack_n
);
    // ==========================================================
    // Registers and state
    ext_bus_pkg::bus_state_e state_reg;
    logic [ext_bus_pkg::CNT_W-1:0] cnt_reg;
    logic [31:0] ctrl_reg;
    logic [19:0] xaddr_reg;
    logic [15:0] xdata_reg;
    logic [15:0] rdata_reg;
    logic extMode_reg;
    logic bootSeen_reg;
    logic waitSettled_reg;
    logic startPending;
    logic isWrite;
    logic singleStrobe;
    logic muxBus;
    logic wordAcc;
    logic wide;
    logic active;
    logic lowS_next;
    logic highS_next;
    logic rdS_next;
    logic [3:0] cs_next;

    assign isWrite = ctrl_reg[ext_bus_pkg::CTRL_WRITE_BIT];
    // Single strobe forced on an 8-bit bus to protect a misconfigured setup
    assign singleStrobe =
        ctrl_reg[ext_bus_pkg::CTRL_SINGLE_STROBE_BIT] | ~wide; // [RULE_15]
    assign muxBus = ctrl_reg[ext_bus_pkg::CTRL_MUX_BIT];
    assign wordAcc = ctrl_reg[ext_bus_pkg::CTRL_WORD_BIT] & wide;
    assign wide = ~byteWidthSel; // [RULE_02]
    assign startPending = ctrl_reg[ext_bus_pkg::CTRL_GO_BIT];
    assign active = (state_reg == ext_bus_pkg::ST_STROBE);

    function automatic logic [7:0] mux_addr(input logic [19:0] a,
                                            input logic w);
        mux_addr = w ? a[8:1] : a[7:0]; // [RULE_06] [RULE_07]
    endfunction : mux_addr

    // ==========================================================
    // Boot mode is sampled once after reset release
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin // [RULE_20]
            bootSeen_reg <= 1'b0;
            extMode_reg <= 1'b0;
        end else if (!bootSeen_reg) begin
            bootSeen_reg <= 1'b1;
            extMode_reg <= bootModeSelect; // [RULE_01]
        end
    end

    // ==========================================================
    // Bus state machine
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= ext_bus_pkg::ST_IDLE;
            cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                ext_bus_pkg::ST_IDLE: begin
                    if (!holdReq_n) begin
                        state_reg <= ext_bus_pkg::ST_HOLD; // [RULE_17]
                    end else if (startPending && extMode_reg) begin
                        state_reg <= ext_bus_pkg::ST_ADDR;
                        cnt_reg <= ext_bus_pkg::CNT_W'(
                            ext_bus_pkg::ALE_CYCLES - 1);
                    end
                end
                ext_bus_pkg::ST_ADDR: begin
                    if (cnt_reg == '0) begin
                        state_reg <= ext_bus_pkg::ST_STROBE;
                        cnt_reg <= ext_bus_pkg::CNT_W'(
                            ext_bus_pkg::STROBE_CYCLES - 1);
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                ext_bus_pkg::ST_STROBE: begin
                    if (cnt_reg != '0) begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end else if (waitReq_n) begin // [RULE_19]
                        state_reg <= ext_bus_pkg::ST_RECOVER;
                    end
                end
                ext_bus_pkg::ST_RECOVER: begin
                    state_reg <= ext_bus_pkg::ST_IDLE;
                end
                ext_bus_pkg::ST_HOLD: begin
                    if (holdReq_n) begin
                        state_reg <= ext_bus_pkg::ST_IDLE; // [RULE_17]
                    end
                end
                default: begin
                    state_reg <= ext_bus_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Read data capture at the end of the strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_reg <= '0;
        end else if (active && cnt_reg == '0 && waitReq_n && !isWrite) begin
            rdata_reg[7:0] <= dataIn[7:0]; // [RULE_04]
            rdata_reg[15:8] <= (wordAcc && !muxBus) ? dataIn[15:8] : 8'h00;
        end
    end

    // ==========================================================
    // Avalon-MM slave: one wait cycle on every request, so that
    // waitrequest can come straight from a flop
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= ext_bus_pkg::CTRL_RESET;
            xaddr_reg <= '0;
            xdata_reg <= '0;
        end else begin
            if (state_reg == ext_bus_pkg::ST_RECOVER) begin
                ctrl_reg[ext_bus_pkg::CTRL_GO_BIT] <= 1'b0;
            end
            // Address and data are frozen during an access
            if (write && !waitrequest && !startPending) begin
                unique case (address)
                    ext_bus_pkg::CTRL_OFFSET: begin
                        if (byteenable[0]) begin
                            ctrl_reg[7:0] <= writedata[7:0]; // [RULE_09]
                        end
                    end
                    ext_bus_pkg::ADDR_OFFSET: begin
                        xaddr_reg <= writedata[19:0];
                    end
                    ext_bus_pkg::DATA_OFFSET: begin
                        xdata_reg <= writedata[15:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            waitrequest <= 1'b1;
            readdata <= ext_bus_pkg::UNMAPPED_READ;
        end else begin
            waitrequest <= !((read || write) && waitrequest);
            if (read && waitrequest) begin
                unique case (address)
                    ext_bus_pkg::CTRL_OFFSET: readdata <= ctrl_reg;
                    ext_bus_pkg::ADDR_OFFSET: readdata <= {12'h000, xaddr_reg};
                    ext_bus_pkg::DATA_OFFSET: readdata <= {16'h0000, rdata_reg};
                    ext_bus_pkg::STAT_OFFSET: readdata <= {28'h0000000,
                        extMode_reg, wide,
                        state_reg == ext_bus_pkg::ST_HOLD, startPending};
                    default: readdata <= ext_bus_pkg::UNMAPPED_READ;
                endcase
            end
        end
    end

    // ==========================================================
    // Pin drivers, all registered
    strobe_decode u_decode (
        .active(active),
        .isWrite(isWrite),
        .singleStrobe(singleStrobe),
        .oddAddr(xaddr_reg[0]),
        .bothLanes(wordAcc),
        .space(xaddr_reg[ext_bus_pkg::SPACE_HI_BIT:
                         ext_bus_pkg::SPACE_LO_BIT]),
        .lowStrobe_n(lowS_next),
        .highStrobe_n(highS_next),
        .readStrobe_n(rdS_next),
        .spaceSel_n(cs_next)
    );

    logic inCycle;
    assign inCycle = state_reg == ext_bus_pkg::ST_ADDR || active;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin // [RULE_21]
            even_byte_store_strobe_n <= 1'b1;
            odd_byte_store_strobe_n <= 1'b1;
            readStrobe_n <= 1'b1;
            space_select_n <= 4'hF;
            bus_grant_ack_n <= 1'b1;
            addrLatch <= 1'b0;
            addrOut <= '0;
            dataOut <= '0;
            dataOe_n <= 16'hFFFF;
        end else begin
            even_byte_store_strobe_n <= lowS_next;
            odd_byte_store_strobe_n <= highS_next;
            readStrobe_n <= rdS_next;
            space_select_n <= inCycle ? (active ? cs_next :
                4'hF & ~(4'h1 << xaddr_reg[19:18])) : 4'hF; // [RULE_08]
            bus_grant_ack_n <= !(state_reg == ext_bus_pkg::ST_HOLD
                                 && !holdReq_n); // [RULE_18]
            addrLatch <= state_reg == ext_bus_pkg::ST_ADDR
                         && cnt_reg != '0; // [RULE_16] [RULE_22]
            addrOut <= inCycle ? xaddr_reg : '0; // [RULE_05]
            if (state_reg == ext_bus_pkg::ST_ADDR && muxBus) begin
                dataOut <= {8'h00, mux_addr(xaddr_reg, wide)};
                dataOe_n <= 16'hFF00;
            end else if (active && isWrite) begin
                dataOut <= xdata_reg;
                dataOe_n <= (wordAcc && !muxBus) ? 16'h0000 : 16'hFF00;
            end else begin
                dataOut <= '0;
                dataOe_n <= 16'hFFFF;
            end
        end
    end

    // ==========================================================
    // Checks
    sequence hold_seen;
        !holdReq_n && state_reg == ext_bus_pkg::ST_HOLD;
    endsequence
    hold_ack_a: assert property (@(posedge clk) disable iff (reset)
        hold_seen |=> !bus_grant_ack_n) // [RULE_18]
        else $error("grant ack not low in hold");
    hold_enter_a: assert property (@(posedge clk) disable iff (reset)
        state_reg == ext_bus_pkg::ST_IDLE && !holdReq_n
        |=> state_reg == ext_bus_pkg::ST_HOLD) // [RULE_17]
        else $error("hold not entered");
    wait_stretch_a: assert property (@(posedge clk) disable iff (reset)
        active && cnt_reg == '0 && !waitReq_n |=> active) // [RULE_19]
        else $error("cycle ended during wait");
    rd_strobe_a: assert property (@(posedge clk) disable iff (reset)
        active && !isWrite |=> !readStrobe_n) // [RULE_12]
        else $error("read strobe missing");
    wr_single_a: assert property (@(posedge clk) disable iff (reset)
        active && isWrite && singleStrobe
        |=> !even_byte_store_strobe_n) // [RULE_13]
        else $error("single write strobe missing");
    idle_high_a: assert property (@(posedge clk) disable iff (reset)
        state_reg == ext_bus_pkg::ST_IDLE |=> readStrobe_n
        && even_byte_store_strobe_n && space_select_n == 4'hF) // [RULE_21]
        else $error("strobes not idle high");
    ale_addr_a: assert property (@(posedge clk) disable iff (reset)
        addrLatch |-> $past(state_reg) == ext_bus_pkg::ST_ADDR) // [RULE_22]
        else $error("latch outside address phase");
    ale_data_a: assert property (@(posedge clk) disable iff (reset)
        addrLatch |-> dataOe_n != 16'h0000 && readStrobe_n) // [RULE_22]
        else $error("latch overlaps data phase");
endmodule : ext_bus_if

/* design/ext_bus_pkg.sv */
// Purpose: constants for the external memory bus interface
// Assumes: 100 MHz clk, Avalon-MM register slave with waitrequest
// Notes: word offsets are byte addresses on a 32-bit bus
//
// Overview of operation
// [RULE_01] Board ties boot-mode pin low for single-chip, high for external bus.
// [RULE_02] Bus-width pin low gives a 16-bit data bus, high an 8-bit one.
// [RULE_03] Board keeps bus-width pin fixed, and grounded in single-chip mode.
// [RULE_04] Separate bus moves low byte always, high byte only when 16 bits wide.
// [RULE_05] Address bits 0 to 19 driven out during external accesses.
// [RULE_06] 8-bit multiplexed bus: address bits 0-7 first, then data 0-7.
// [RULE_07] 16-bit multiplexed bus: address bits 1-8 first, then data 0-7.
// [RULE_08] Four chip selects, each marking its own address space.
// [RULE_09] Software picks split write strobes or single strobe plus byte enable.
// [RULE_10] Split scheme: even-byte strobe low on write to even address.
// [RULE_11] Split scheme: odd-byte strobe low on write to odd address.
// [RULE_12] Read strobe low while reading external space, either scheme.
// [RULE_13] Single scheme: write strobe low on any external write.
// [RULE_14] Single scheme: upper-byte enable low on any odd-address access.
// [RULE_15] Software must pick single scheme whenever the bus is 8 bits wide.
// [RULE_16] Address latch pulse lets external logic capture the address.
// [RULE_17] Hold request low puts device in hold, releasing the external bus.
// [RULE_18] Grant acknowledge low for as long as the hold state lasts.
// [RULE_19] Wait request low stretches the current external bus cycle.
// [RULE_20] Device stays in reset while reset input is asserted.
// [RULE_21] Strobes, selects and acknowledge idle high, including after reset.
// [RULE_22] Address latch pulse only in address phase, gone before data phase.

package ext_bus_pkg;
    // ==========================================================
    // Register map
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] ADDR_OFFSET = 4'h4;
    localparam logic [3:0] DATA_OFFSET = 4'h8;
    localparam logic [3:0] STAT_OFFSET = 4'hC;
    // Control fields
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_WRITE_BIT = 1;
    localparam int CTRL_SINGLE_STROBE_BIT = 2;
    localparam int CTRL_MUX_BIT = 3;
    localparam int CTRL_WORD_BIT = 4;
    // Status fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_HOLD_BIT = 1;
    localparam int STAT_WIDE_BIT = 2;
    localparam int STAT_EXT_BIT = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    // ==========================================================
    // Address space split for chip selects: top two address bits
    localparam int SPACE_HI_BIT = 19;
    localparam int SPACE_LO_BIT = 18;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int ALE_TIME_NS = 20;
    localparam int STROBE_TIME_NS = 30;
    localparam int ALE_CYCLES =
        (ALE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYCLES =
        (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    // ==========================================================
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_STROBE = 3'b010,
        ST_RECOVER = 3'b011,
        ST_HOLD = 3'b100
    } bus_state_e;
endpackage : ext_bus_pkg

/* design/strobe_decode.sv */
// Purpose: decodes bus strobes, byte lanes and chip selects
// Assumes: inputs are registered state of the main bus engine and the bus-width pin
// Notes: purely combinational, registered by the caller
`timescale 1ns/10ps
module strobe_decode (
    input wire logic active,
    input wire logic isWrite,
    input wire logic singleStrobe,
    input wire logic oddAddr,
    input wire logic bothLanes,
    input wire logic [1:0] space,
    output logic lowStrobe_n,
    output logic highStrobe_n,
    output logic readStrobe_n,
    output logic [3:0] spaceSel_n
);
    always_comb begin
        readStrobe_n = ~(active & ~isWrite); // [RULE_12]
        if (singleStrobe) begin
            lowStrobe_n = ~(active & isWrite); // [RULE_13]
            // A word access needs the upper byte as well
            highStrobe_n = ~(active & (oddAddr | bothLanes)); // [RULE_14]
        end else begin
            // A word write to an even address fires both byte strobes
            lowStrobe_n =
                ~(active & isWrite & (~oddAddr | bothLanes)); // [RULE_10]
            highStrobe_n =
                ~(active & isWrite & (oddAddr | bothLanes)); // [RULE_11]
        end
        spaceSel_n = 4'hF;
        if (active) begin
            spaceSel_n[space] = 1'b0; // [RULE_08]
        end
    end
endmodule : strobe_decode

/* test/ext_mem_model.sv */
// Purpose: far-side memory on the external bus, with probe flags
// Assumes: one access at a time; board strobe wiring set by singleWired
// Notes: released data lines show the inverse of the last value
`timescale 1ns/10ps
module ext_mem_model (
    input wire logic clk,
    input wire logic singleWired,
    input wire logic [3:0] waitCycles,
    input wire logic [19:0] addrOut,
    input wire logic [15:0] dataOut,
    input wire logic [15:0] dataOe_n,
    input wire logic addrLatch,
    input wire logic [3:0] space_select_n,
    input wire logic even_byte_store_strobe_n,
    input wire logic odd_byte_store_strobe_n,
    input wire logic readStrobe_n,
    output logic [15:0] dataIn,
    output logic waitReq_n
);
    logic [15:0] mem [16];
    logic [15:0] junk;
    logic [19:0] latAddr;
    logic [7:0] latMux, readLen;
    logic [3:0] selSeen, waitCnt;
    logic evenSeen, oddSeen, readSeen, hiLane, aleOverlap, aleLast;
    logic newAcc, wrNow, active;
    // ==========================================================
    // Strobe decode as the board is wired
    assign newAcc = addrLatch && !aleLast;
    assign wrNow = !even_byte_store_strobe_n ||
        (!singleWired && !odd_byte_store_strobe_n);
    assign active = wrNow || !readStrobe_n;
    assign waitReq_n = !(active && waitCnt < waitCycles);
    // Unknowns would settle by chance, so idle lines show the inverse of the last dataOut or dataIn
    assign dataIn = readStrobe_n ? junk : mem[latAddr[3:0]];
    always_ff @(posedge clk) begin
        junk <= ~(readStrobe_n ? dataOut : dataIn);
        aleLast <= addrLatch;
        if (!active)
            waitCnt <= 4'h0;
        else if (waitCnt < waitCycles)
            waitCnt <= waitCnt + 4'h1;
        if (newAcc) begin
            latAddr <= addrOut;
            latMux <= dataOut[7:0];
        end
        selSeen <= (newAcc ? 4'h0 : selSeen) | ~space_select_n;
        evenSeen <= (!newAcc && evenSeen) || !even_byte_store_strobe_n;
        oddSeen <= (!newAcc && oddSeen) || !odd_byte_store_strobe_n;
        readSeen <= (!newAcc && readSeen) || !readStrobe_n;
        readLen <= (newAcc ? 8'h00 : readLen) + 8'(!readStrobe_n);
        hiLane <= (!newAcc && hiLane) || !(&dataOe_n[15:8]);
        aleOverlap <= (!newAcc && aleOverlap) || (addrLatch && active);
        if (wrNow && readStrobe_n)
            mem[latAddr[3:0]] <= (mem[latAddr[3:0]] & dataOe_n) |
                (dataOut & ~dataOe_n);
    end
endmodule : ext_mem_model

/* test/test_ext_bus_if.sv */
// Purpose: self-checking bench for the external bus engine
// Assumes: register access over Avalon-MM, one bus access at a time
// Notes: strobe and address probes come from the memory model
`timescale 1ns/10ps
module test_ext_bus_if;
    typedef struct packed {
        logic eight, single, mux, wr, word;
        logic [3:0] wt;
        logic [19:0] adr;
        logic [15:0] dat;
    } acc_s;
    localparam int LIMIT = 5000;
    logic clk, reset, read, write, waitrequest, bootModeSelect;
    logic byteWidthSel, holdReq_n, waitReq_n, addrLatch, readStrobe_n;
    logic even_byte_store_strobe_n, odd_byte_store_strobe_n;
    logic bus_grant_ack_n, singleWired, bad;
    logic [3:0] address, byteenable, space_select_n, waitCycles;
    logic [31:0] writedata, readdata, rd;
    logic [19:0] addrOut;
    logic [15:0] dataOut, dataOe_n, dataIn;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    acc_s tbl [8];
    ext_bus_if i_dut (.clk, .reset, .address, .read, .write, .writedata,
        .byteenable, .readdata, .waitrequest, .bootModeSelect, .byteWidthSel,
        .holdReq_n, .waitReq_n, .addrOut, .dataOut, .dataOe_n, .dataIn,
        .addrLatch, .space_select_n, .even_byte_store_strobe_n,
        .odd_byte_store_strobe_n, .readStrobe_n, .bus_grant_ack_n);
    ext_mem_model i_mem (.clk, .singleWired, .waitCycles, .addrOut,
        .dataOut, .dataOe_n, .addrLatch, .space_select_n,
        .even_byte_store_strobe_n, .odd_byte_store_strobe_n, .readStrobe_n,
        .dataIn, .waitReq_n);
    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
            input string msg);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    task automatic avWrite(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= 1'h1;
        do @(posedge clk); while (waitrequest !== 1'h0);
        write <= 1'h0;
    endtask : avWrite
    task automatic avRead(input logic [3:0] a);
        @(posedge clk);
        address <= a;
        read <= 1'h1;
        do @(posedge clk); while (waitrequest !== 1'h0);
        rd = readdata;
        read <= 1'h0;
    endtask : avRead
    task automatic waitIdle();
        do avRead(ext_bus_pkg::STAT_OFFSET);
        while (rd[ext_bus_pkg::STAT_BUSY_BIT] !== 1'h0);
    endtask : waitIdle
    task automatic checkIdle();
        check(32'({space_select_n, even_byte_store_strobe_n,
            odd_byte_store_strobe_n, readStrobe_n, bus_grant_ack_n,
            addrLatch, dataOe_n}), 32'({8'hFF, 1'h0, 16'hFFFF}), "idle");
    endtask : checkIdle
    task automatic access(input acc_s t);
        logic [31:0] c;
        logic sch;
        c = 32'h0;
        sch = t.single | t.eight;
        c[ext_bus_pkg::CTRL_GO_BIT] = 1'h1;
        c[ext_bus_pkg::CTRL_WRITE_BIT] = t.wr;
        c[ext_bus_pkg::CTRL_SINGLE_STROBE_BIT] = sch;
        c[ext_bus_pkg::CTRL_MUX_BIT] = t.mux;
        c[ext_bus_pkg::CTRL_WORD_BIT] = t.word;
        // Width pin only moves while the bus is idle
        byteWidthSel <= t.eight;
        singleWired <= sch;
        waitCycles <= t.wt;
        avWrite(ext_bus_pkg::ADDR_OFFSET, 32'(t.adr));
        if (t.wr)
            avWrite(ext_bus_pkg::DATA_OFFSET, 32'(t.dat));
        avWrite(ext_bus_pkg::CTRL_OFFSET, c);
        waitIdle();
        check(32'(rd[ext_bus_pkg::STAT_WIDE_BIT]), 32'(!t.eight), "width");
        check(32'(i_mem.selSeen), 32'(4'h1 << t.adr[19:18]), "select");
        check(32'(i_mem.evenSeen), 32'(t.wr && (sch || !t.adr[0])), "even");
        check(32'(i_mem.oddSeen), 32'((sch || t.wr) && (t.adr[0] || t.word)), "odd");
        check(32'(i_mem.readSeen), 32'(!t.wr), "read strobe");
        check(32'(i_mem.hiLane), 32'(t.wr && t.word), "upper lane");
        check(32'(i_mem.aleOverlap), 32'h0, "latch overlap");
        if (t.mux)
            check(32'(i_mem.latMux), 32'(t.eight ? t.adr[7:0] : t.adr[8:1]), "mux addr");
        else
            check(32'(i_mem.latAddr), 32'(t.adr), "address");
        if (!t.wr) begin
            avRead(ext_bus_pkg::DATA_OFFSET);
            check(rd & (t.word ? 32'hFFFF : 32'hFF), 32'(t.dat), "data");
            // Partner wait overlaps the first strobe cycle
            check(32'(8'(i_mem.readLen + 8'h01 - t.wt - ext_bus_pkg::STROBE_CYCLES) <= 8'h01), 32'h1, "wait");
        end
        $display("test access %h done", t.adr);
    endtask : access
    // ==========================================================
    // Clock and hang guard
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            print_verdict();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        tbl = '{'{1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 4'h0, 20'h00004, 16'hA55A},
            '{1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 4'h2, 20'h40007, 16'h003C},
            '{1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 4'h1, 20'h80002, 16'h00C3},
            '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 4'h0, 20'hC0009, 16'h0096},
            '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 4'h3, 20'h00004, 16'hA55A},
            '{1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 4'h0, 20'h40007, 16'h003C},
            '{1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 4'h0, 20'h80002, 16'h00C3},
            '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 4'h2, 20'hC0009, 16'h0096}};
        reset = 1'h1;
        read = 1'h0;
        write = 1'h0;
        address = 4'h0;
        writedata = 32'h0;
        byteenable = 4'hF;
        bootModeSelect = 1'h1;
        byteWidthSel = 1'h0;
        holdReq_n = 1'h1;
        singleWired = 1'h0;
        waitCycles = 4'h0;
        repeat (16) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        checkIdle();
        avRead(ext_bus_pkg::CTRL_OFFSET);
        check(rd, ext_bus_pkg::CTRL_RESET, "control reset");
        avRead(4'h2);
        check(rd, ext_bus_pkg::UNMAPPED_READ, "unmapped");
        avRead(ext_bus_pkg::STAT_OFFSET);
        check(32'(rd[ext_bus_pkg::STAT_EXT_BIT]), 32'h1, "boot mode");
        $display("test reset done");
        foreach (tbl[i])
            access(tbl[i]);
        // A request made while held must wait for the release
        holdReq_n <= 1'h0;
        singleWired <= 1'h0;
        byteWidthSel <= 1'h0;
        repeat (3) @(posedge clk);
        check(32'(bus_grant_ack_n), 32'h0, "grant");
        avRead(ext_bus_pkg::STAT_OFFSET);
        check(32'(rd[ext_bus_pkg::STAT_HOLD_BIT]), 32'h1, "hold");
        avWrite(ext_bus_pkg::ADDR_OFFSET, 32'h40006);
        avWrite(ext_bus_pkg::CTRL_OFFSET, 32'h1);
        bad = 1'h0;
        repeat (12) begin
            @(posedge clk);
            bad |= readStrobe_n !== 1'h1 || addrLatch !== 1'h0 ||
                space_select_n !== 4'hF || bus_grant_ack_n !== 1'h0;
        end
        check(32'(bad), 32'h0, "bus kept in hold");
        holdReq_n <= 1'h1;
        waitIdle();
        check(32'(bus_grant_ack_n), 32'h1, "grant released");
        check(32'(i_mem.readSeen), 32'h1, "held read done");
        $display("test hold done");
        waitCycles <= 4'h8;
        avWrite(ext_bus_pkg::ADDR_OFFSET, 32'h00001);
        avWrite(ext_bus_pkg::CTRL_OFFSET, 32'h3);
        repeat (6) @(posedge clk);
        reset <= 1'h1;
        repeat (2) @(posedge clk);
        checkIdle();
        bootModeSelect <= 1'h0;
        reset <= 1'h0;
        @(posedge clk);
        checkIdle();
        avRead(ext_bus_pkg::STAT_OFFSET);
        check(32'(rd[ext_bus_pkg::STAT_BUSY_BIT]), 32'h0, "busy cleared");
        check(32'(rd[ext_bus_pkg::STAT_EXT_BIT]), 32'h0, "single-chip");
        $display("test reset mid-run done");
        print_verdict();
    end
endmodule : test_ext_bus_if
